// ---- verilog/lmm_top.sv ----
// Load monitor teaching/monitor mode control with alarm and warning reset
//
// Function
// - Execution rising during automatic operation activates teaching or monitoring.
// - Mode select inputs at activation choose teaching or monitoring.
// - Execution falling ends teaching or monitoring at once.
// - Execution is ignored while neither mode select is on.
// - Teaching entered only when teaching select on, then execution rises.
// - Monitoring entered only when monitor select on, then execution rises.
// - Alarm reset rising clears all alarm axis and data alarm bits.
// - Alarm reset also clears all warning bits.
// - Alarm reset touches only alarm and warning information and its clear interrupt status bits, never the mode.
// - Warning reset rising clears all warning axis bits.
// - Warning reset alone leaves alarm bits untouched.
`timescale 1ns/1ps
module lmm_top #(
    parameter int AXES = lmm_pkg::AXES_DEF,
    parameter int DALM_W = lmm_pkg::DALM_W_DEF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Sequence program inputs
    input wire lmm_pkg::lmm_ctl_s seq_ctl_in,
    input wire logic auto_op_in,
    // Load monitor core events
    input wire logic [AXES-1:0] alarm_axis_set_in,
    input wire logic [DALM_W-1:0] data_alarm_set_in,
    input wire logic [AXES-1:0] warn_axis_set_in,
    // Mode outputs
    output logic exec_active_out,
    output logic teach_valid_out,
    output logic monitor_valid_out,
    // Alarm and warning information
    output logic [AXES-1:0] alarm_axis_out,
    output logic [DALM_W-1:0] data_alarm_out,
    output logic [AXES-1:0] warn_axis_out,
    // Interrupt
    output logic irq_out,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    // ==================================================================
    // Input edges, one sample per scan
    lmm_pkg::lmm_ctl_s ctl_rise;
    logic [lmm_pkg::CTL_W-1:0] ctl_rise_vec;

    lmm_rise #(
        .W(lmm_pkg::CTL_W)
    ) u_rise (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .level_in(seq_ctl_in),
        .rise_out(ctl_rise_vec)
    );

    assign ctl_rise = lmm_pkg::lmm_ctl_s'(ctl_rise_vec);

    // ==================================================================
    // Control register
    logic ctrl_enable_q;
    logic ctrl_enable_d;

    // ==================================================================
    // Mode state machine
    lmm_pkg::lmm_mode_e mode_q;
    lmm_pkg::lmm_mode_e mode_d;
    logic act_q;
    logic teach_q;
    logic mon_q;
    wire logic exec_rise = ctl_rise.load_watch_execute;
    wire logic exec_level = seq_ctl_in.load_watch_execute;
    wire logic sel_teach_only = seq_ctl_in.teach_sel & ~seq_ctl_in.mon_sel;
    wire logic sel_mon_only = seq_ctl_in.mon_sel & ~seq_ctl_in.teach_sel;
    wire logic sel_both = seq_ctl_in.teach_sel & seq_ctl_in.mon_sel;
    wire logic start_ok = exec_rise & auto_op_in & ctrl_enable_q;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            lmm_pkg::LMM_IDLE: begin
                if (start_ok && sel_teach_only) begin
                    mode_d = lmm_pkg::LMM_TEACH;
                end else if (start_ok && sel_mon_only) begin
                    mode_d = lmm_pkg::LMM_MONITOR;
                end else if (start_ok && sel_both) begin
                    mode_d = lmm_pkg::LMM_REJECT;
                end else begin
                    mode_d = lmm_pkg::LMM_IDLE;
                end
            end
            lmm_pkg::LMM_TEACH, lmm_pkg::LMM_MONITOR, lmm_pkg::LMM_REJECT: begin
                if (!exec_level) begin
                    mode_d = lmm_pkg::LMM_IDLE;
                end
            end
            default: begin
                mode_d = lmm_pkg::LMM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_q <= lmm_pkg::LMM_IDLE;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire logic mode_active_q = (mode_q == lmm_pkg::LMM_TEACH) ||
        (mode_q == lmm_pkg::LMM_MONITOR);
    wire logic mode_active_d = (mode_d == lmm_pkg::LMM_TEACH) ||
        (mode_d == lmm_pkg::LMM_MONITOR);
    wire logic ev_enter = mode_active_d & ~mode_active_q;
    wire logic ev_leave = mode_active_q & ~mode_active_d;
    wire logic ev_reject = (mode_d == lmm_pkg::LMM_REJECT) &&
        (mode_q != lmm_pkg::LMM_REJECT);

    // ==================================================================
    // Alarm and warning information
    logic [AXES-1:0] alarm_axis;
    logic [DALM_W-1:0] data_alarm;
    logic [AXES-1:0] warn_axis;
    wire logic alarm_any = (|alarm_axis) | (|data_alarm);
    wire logic warn_any = |warn_axis;
    // Alarm reset only drives these clears; the mode machine never sees it
    wire logic alarm_clr = ctl_rise.alarm_rst & alarm_any;
    wire logic warn_clr = (ctl_rise.alarm_rst | ctl_rise.warn_rst) & warn_any;
    wire logic [AXES-1:0] alarm_axis_clr = {AXES{alarm_clr}};
    wire logic [DALM_W-1:0] data_alarm_clr = {DALM_W{alarm_clr}};
    wire logic [AXES-1:0] warn_axis_clr = {AXES{warn_clr}};

    lmm_flags #(
        .W(AXES)
    ) u_alarm_axis (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(alarm_axis_set_in),
        .clr_in(alarm_axis_clr),
        .flag_out(alarm_axis)
    );

    lmm_flags #(
        .W(DALM_W)
    ) u_data_alarm (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(data_alarm_set_in),
        .clr_in(data_alarm_clr),
        .flag_out(data_alarm)
    );

    lmm_flags #(
        .W(AXES)
    ) u_warn_axis (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(warn_axis_set_in),
        .clr_in(warn_axis_clr),
        .flag_out(warn_axis)
    );

    // ==================================================================
    // Avalon-MM slave: one wait cycle per access
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wire logic req = avs_read_in | avs_write_in;
    wire logic accept = req & ~wait_q;
    wire logic wr_lane0 = avs_write_in & accept & avs_byteenable_in[0];
    wire logic sel_ctrl = (avs_address_in == lmm_pkg::OFS_CTRL);
    wire logic sel_irq_en = (avs_address_in == lmm_pkg::OFS_IRQ_EN);
    wire logic sel_irq_clr = (avs_address_in == lmm_pkg::OFS_IRQ_CLR);
    wire logic wr_ctrl = wr_lane0 & sel_ctrl;
    wire logic wr_irq_en = wr_lane0 & sel_irq_en;
    wire logic wr_irq_clr = wr_lane0 & sel_irq_clr;

    assign ctrl_enable_d = wr_ctrl ? avs_writedata_in[lmm_pkg::CTRL_ENABLE] : ctrl_enable_q;

    // ==================================================================
    // Interrupt status, enable and clear
    logic [lmm_pkg::IRQ_W-1:0] irq_stat;
    logic [lmm_pkg::IRQ_W-1:0] irq_en_q;
    logic [lmm_pkg::IRQ_W-1:0] irq_en_d;
    logic [lmm_pkg::IRQ_W-1:0] irq_set;
    logic irq_q;
    wire logic [lmm_pkg::IRQ_W-1:0] irq_clr =
        wr_irq_clr ? avs_writedata_in[lmm_pkg::IRQ_W-1:0] : '0;

    always_comb begin
        irq_set = '0;
        irq_set[lmm_pkg::IRQ_ENTER] = ev_enter;
        irq_set[lmm_pkg::IRQ_LEAVE] = ev_leave;
        irq_set[lmm_pkg::IRQ_REJECT] = ev_reject;
        irq_set[lmm_pkg::IRQ_ALM_CLR] = alarm_clr;
        irq_set[lmm_pkg::IRQ_WRN_CLR] = warn_clr;
    end

    lmm_flags #(
        .W(lmm_pkg::IRQ_W)
    ) u_irq_stat (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(irq_set),
        .clr_in(irq_clr),
        .flag_out(irq_stat)
    );

    assign irq_en_d = wr_irq_en ? avs_writedata_in[lmm_pkg::IRQ_W-1:0] : irq_en_q;

    // ==================================================================
    // Read words
    logic [31:0] status_word;
    logic [31:0] alarm_word;
    logic [31:0] warn_word;

    always_comb begin
        status_word = '0;
        status_word[lmm_pkg::ST_EXEC] = mode_active_q;
        status_word[lmm_pkg::ST_TEACH] = (mode_q == lmm_pkg::LMM_TEACH);
        status_word[lmm_pkg::ST_MON] = (mode_q == lmm_pkg::LMM_MONITOR);
        status_word[lmm_pkg::ST_REJECT] = (mode_q == lmm_pkg::LMM_REJECT);
        status_word[lmm_pkg::ST_ENABLE] = ctrl_enable_q;
        status_word[lmm_pkg::ST_AUTO] = auto_op_in;
        status_word[lmm_pkg::ST_INPUTS +: lmm_pkg::CTL_W] = seq_ctl_in;
        alarm_word = '0;
        alarm_word[lmm_pkg::ALM_AXIS +: AXES] = alarm_axis;
        alarm_word[lmm_pkg::ALM_DATA +: DALM_W] = data_alarm;
        warn_word = '0;
        warn_word[AXES-1:0] = warn_axis;
    end

    always_comb begin
        case (avs_address_in)
            lmm_pkg::OFS_STATUS: begin
                rdata_d = status_word;
            end
            lmm_pkg::OFS_ALARM: begin
                rdata_d = alarm_word;
            end
            lmm_pkg::OFS_WARN: begin
                rdata_d = warn_word;
            end
            lmm_pkg::OFS_CTRL: begin
                rdata_d = {31'h00000000, ctrl_enable_q};
            end
            lmm_pkg::OFS_IRQ_STAT: begin
                rdata_d = {27'h0000000, irq_stat};
            end
            lmm_pkg::OFS_IRQ_EN: begin
                rdata_d = {27'h0000000, irq_en_q};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (avs_read_in && wait_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_enable_q <= lmm_pkg::CTRL_RST;
            irq_en_q <= lmm_pkg::IRQ_EN_RST;
            irq_q <= 1'b0;
            act_q <= 1'b0;
            teach_q <= 1'b0;
            mon_q <= 1'b0;
        end else begin
            ctrl_enable_q <= ctrl_enable_d;
            irq_en_q <= irq_en_d;
            irq_q <= |(irq_stat & irq_en_q);
            act_q <= mode_active_d;
            teach_q <= (mode_d == lmm_pkg::LMM_TEACH);
            mon_q <= (mode_d == lmm_pkg::LMM_MONITOR);
        end
    end

    // ==================================================================
    // Outputs
    assign exec_active_out = act_q;
    assign teach_valid_out = teach_q;
    assign monitor_valid_out = mon_q;
    assign alarm_axis_out = alarm_axis;
    assign data_alarm_out = data_alarm;
    assign warn_axis_out = warn_axis;
    assign irq_out = irq_q;
    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;

endmodule

// ---- verilog/lmm_pkg.sv ----
// Package: constants, types and register map of the load monitor mode control
package lmm_pkg;

    // ==================================================================
    // Sizes
    localparam int AXES_DEF = 8;
    localparam int DALM_W_DEF = 8;
    localparam int CTL_W = 5;
    localparam int IRQ_W = 5;

    // ==================================================================
    // Register byte offsets
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_ALARM = 5'h04;
    localparam logic [4:0] OFS_WARN = 5'h08;
    localparam logic [4:0] OFS_CTRL = 5'h0C;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFS_IRQ_EN = 5'h14;
    localparam logic [4:0] OFS_IRQ_CLR = 5'h18;

    // ==================================================================
    // Status register fields
    localparam int ST_EXEC = 0;
    localparam int ST_TEACH = 1;
    localparam int ST_MON = 2;
    localparam int ST_REJECT = 3;
    localparam int ST_ENABLE = 4;
    localparam int ST_AUTO = 5;
    localparam int ST_INPUTS = 8;

    // Alarm register fields
    localparam int ALM_AXIS = 0;
    localparam int ALM_DATA = 16;

    // ==================================================================
    // Control register
    localparam int CTRL_ENABLE = 0;
    localparam logic CTRL_RST = 1'h1;

    // ==================================================================
    // Interrupt bits
    localparam int IRQ_ENTER = 0;
    localparam int IRQ_LEAVE = 1;
    localparam int IRQ_REJECT = 2;
    localparam int IRQ_ALM_CLR = 3;
    localparam int IRQ_WRN_CLR = 4;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {
        LMM_IDLE = 2'b00,
        LMM_TEACH = 2'b01,
        LMM_MONITOR = 2'b10,
        LMM_REJECT = 2'b11
    } lmm_mode_e;

    typedef struct packed {
        logic warn_rst;
        logic alarm_rst;
        logic mon_sel;
        logic teach_sel;
        logic load_watch_execute;
    } lmm_ctl_s;

endpackage

// ---- verilog/lmm_rise.sv ----
// Per-bit rising edge detector on scan-synchronous inputs
`timescale 1ns/1ps
module lmm_rise #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Levels and edges
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_out
);

    // ==================================================================
    // Previous scan and edge per bit
    logic [W-1:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    prev_q[i] <= 1'b0;
                end else begin
                    prev_q[i] <= level_in[i];
                end
            end
            assign rise_out[i] = level_in[i] & ~prev_q[i];
        end
    endgenerate

endmodule

// ---- verilog/lmm_flags.sv ----
// Bank of sticky flags, a set in the clearing cycle wins
`timescale 1ns/1ps
module lmm_flags #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Set and clear per bit
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    // Flags
    output logic [W-1:0] flag_out
);

    // ==================================================================
    // Flag per bit
    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign flag_d[i] = set_in[i] | (flag_q[i] & ~clr_in[i]);
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    flag_q[i] <= 1'b0;
                end else begin
                    flag_q[i] <= flag_d[i];
                end
            end
        end
    endgenerate

    assign flag_out = flag_q;

endmodule

// ---- verif/lmm_props.sv ----
// Checker: mode and flag assertions for the load monitor mode control
`timescale 1ns/1ps
module lmm_props #(
    parameter int AXES = 8,
    parameter int DALM_W = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Inputs watched
    input wire lmm_pkg::lmm_ctl_s seq_ctl_in,
    input wire logic auto_op_in,
    input wire logic [AXES-1:0] alarm_axis_set_in,
    input wire logic [DALM_W-1:0] data_alarm_set_in,
    input wire logic [AXES-1:0] warn_axis_set_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    // Outputs watched
    input wire logic exec_active_out,
    input wire logic teach_valid_out,
    input wire logic monitor_valid_out,
    input wire logic [AXES-1:0] alarm_axis_out,
    input wire logic [DALM_W-1:0] data_alarm_out,
    input wire logic [AXES-1:0] warn_axis_out,
    input wire logic avs_waitrequest_out
);
    // ==================================================================
    // Enable shadow
    logic en_q;
    wire ex = seq_ctl_in.load_watch_execute;
    wire ts = seq_ctl_in.teach_sel;
    wire ms = seq_ctl_in.mon_sel;
    wire ar = seq_ctl_in.alarm_rst;
    wire wr = seq_ctl_in.warn_rst;
    wire no_set = (alarm_axis_set_in == '0) && (data_alarm_set_in == '0);
    wire ctrl_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
        && (avs_address_in == lmm_pkg::OFS_CTRL);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            en_q <= 1'b1;
        end else if (ctrl_wr) begin
            en_q <= avs_writedata_in[0];
        end
    end
    // ==================================================================
    // Assertions
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_ENTER_TEACH: assert property (
        $rose(ex) && auto_op_in && en_q && ts && !ms |=> teach_valid_out && exec_active_out)
        else $error("teach mode not entered");
    AST_ENTER_MON: assert property (
        $rose(ex) && auto_op_in && en_q && ms && !ts |=> monitor_valid_out && !teach_valid_out)
        else $error("monitor mode not entered");
    AST_LEAVE: assert property (
        $fell(ex) |=> !exec_active_out && !teach_valid_out && !monitor_valid_out)
        else $error("mode kept after execute fell");
    AST_NO_SEL: assert property (
        $rose(ex) && !ts && !ms |=> !exec_active_out [*2])
        else $error("mode entered without select");
    AST_BOTH_SEL: assert property (
        $rose(ex) && ts && ms |=> !teach_valid_out && !monitor_valid_out)
        else $error("mode entered with both selects");
    AST_TEACH_CAUSE: assert property (
        $rose(teach_valid_out) |-> $past(auto_op_in && ts && !ms && ex))
        else $error("teach mode without cause");
    AST_ALARM_CLR: assert property (
        $rose(ar) && no_set |=> alarm_axis_out == '0 && data_alarm_out == '0)
        else $error("alarm bits not cleared");
    AST_ALARM_WARN: assert property (
        $rose(ar) && (|alarm_axis_out) && warn_axis_set_in == '0 |=> warn_axis_out == '0)
        else $error("warning bits kept on alarm reset");
    AST_ALARM_MODE: assert property (
        $rose(ar) && $stable(ex) |=> $stable(teach_valid_out) && $stable(monitor_valid_out))
        else $error("alarm reset changed mode");
    AST_WARN_CLR: assert property (
        $rose(wr) && warn_axis_set_in == '0 |=> warn_axis_out == '0)
        else $error("warning bits not cleared");
    AST_WARN_KEEP: assert property (
        $rose(wr) && !$rose(ar) |=> (alarm_axis_out & $past(alarm_axis_out)) == $past(alarm_axis_out))
        else $error("warning reset touched alarms");
endmodule

bind lmm_top lmm_props #(.AXES(AXES), .DALM_W(DALM_W)) lmm_props_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .seq_ctl_in(seq_ctl_in),
    .auto_op_in(auto_op_in),
    .alarm_axis_set_in(alarm_axis_set_in),
    .data_alarm_set_in(data_alarm_set_in),
    .warn_axis_set_in(warn_axis_set_in),
    .avs_address_in(avs_address_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .exec_active_out(exec_active_out),
    .teach_valid_out(teach_valid_out),
    .monitor_valid_out(monitor_valid_out),
    .alarm_axis_out(alarm_axis_out),
    .data_alarm_out(data_alarm_out),
    .warn_axis_out(warn_axis_out),
    .avs_waitrequest_out(avs_waitrequest_out)
);

// ---- verif/lmm_seq.sv ----
// Partner model: sequence program driving the mode and reset inputs
`timescale 1ns/1ps
module lmm_seq (
    // Clock
    input wire logic clk_in,
    // Sequence outputs
    output lmm_pkg::lmm_ctl_s ctl_out
);
    initial begin
        ctl_out = '0;
    end
    // ==================================================================
    // Actions: sel and exec take one clock edge each, pulse takes two
    task automatic sel(input logic t, input logic m);
        @(posedge clk_in);
        ctl_out.teach_sel <= t;
        ctl_out.mon_sel <= m;
    endtask
    task automatic exec(input logic v);
        @(posedge clk_in);
        ctl_out.load_watch_execute <= v;
    endtask
    task automatic pulse(input logic a, input logic w);
        @(posedge clk_in);
        ctl_out.alarm_rst <= a;
        ctl_out.warn_rst <= w;
        @(posedge clk_in);
        ctl_out.alarm_rst <= 1'b0;
        ctl_out.warn_rst <= 1'b0;
    endtask
endmodule

// ---- verif/lmm_top_tb.sv ----
// Testbench: scenario tasks for the load monitor mode control
`timescale 1ns/1ps
module lmm_top_tb;
    logic clk_in = 1'b0;
    logic sys_rst_in;
    lmm_pkg::lmm_ctl_s seq_ctl;
    logic auto_op;
    logic [7:0] alm_set;
    logic [7:0] dal_set;
    logic [7:0] wrn_set;
    logic exec_act, teach_v, mon_v, irq;
    logic [7:0] alm, dal, wrn;
    logic [4:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic wait_r;
    int num_errors = 0;
    int compares = 0;
    always #50 clk_in = ~clk_in;

    lmm_seq lmm_seq_i (.clk_in(clk_in), .ctl_out(seq_ctl));
    lmm_top lmm_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .seq_ctl_in(seq_ctl),
        .auto_op_in(auto_op), .alarm_axis_set_in(alm_set), .data_alarm_set_in(dal_set),
        .warn_axis_set_in(wrn_set), .exec_active_out(exec_act), .teach_valid_out(teach_v),
        .monitor_valid_out(mon_v), .alarm_axis_out(alm), .data_alarm_out(dal),
        .warn_axis_out(wrn), .irq_out(irq), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r));

    // ==================================================================
    // Common tasks
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int i;
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (wait_r === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20) begin
            num_errors++;
            $display("FAIL %0t bus timeout", $time);
            stop_test();
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        chk(q, exp);
    endtask
    task automatic wrreg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chkm(input logic [2:0] exp);
        chk({29'h0, exec_act, teach_v, mon_v}, {29'h0, exp});
    endtask

    // ==================================================================
    // Scenarios
    task automatic t_regs();
        rdchk(lmm_pkg::OFS_STATUS, 32'h00000030);
        rdchk(lmm_pkg::OFS_CTRL, 32'h00000001);
        rdchk(lmm_pkg::OFS_IRQ_EN, 32'h00000000);
        rdchk(5'h1C, 32'h00000000);
        be <= 4'hE;
        wrreg(lmm_pkg::OFS_CTRL, 32'h00000000);
        rdchk(lmm_pkg::OFS_CTRL, 32'h00000001);
        be <= 4'hF;
    endtask
    task automatic t_mode(input logic t, input logic m, input logic [2:0] exp);
        lmm_seq_i.sel(t, m);
        lmm_seq_i.exec(1'b1);
        step(1);
        chkm(exp);
        lmm_seq_i.pulse(1'b1, 1'b0);
        step(1);
        chkm(exp);
        lmm_seq_i.exec(1'b0);
        step(1);
        chkm(3'b000);
        rdchk(lmm_pkg::OFS_IRQ_STAT, 32'h00000003);
        lmm_seq_i.sel(1'b0, 1'b0);
    endtask
    task automatic t_refuse();
        lmm_seq_i.exec(1'b1);
        step(1);
        chkm(3'b000);
        lmm_seq_i.sel(1'b1, 1'b0);
        step(2);
        chkm(3'b000);
        lmm_seq_i.exec(1'b0);
        @(posedge clk_in);
        auto_op <= 1'b0;
        lmm_seq_i.exec(1'b1);
        step(1);
        chkm(3'b000);
        lmm_seq_i.exec(1'b0);
        @(posedge clk_in);
        auto_op <= 1'b1;
        wrreg(lmm_pkg::OFS_CTRL, 32'h00000000);
        lmm_seq_i.exec(1'b1);
        step(1);
        chkm(3'b000);
        lmm_seq_i.exec(1'b0);
        wrreg(lmm_pkg::OFS_CTRL, 32'h00000001);
        wrreg(lmm_pkg::OFS_IRQ_CLR, 32'h0000001F);
        wrreg(lmm_pkg::OFS_IRQ_EN, 32'h00000004);
        lmm_seq_i.sel(1'b1, 1'b1);
        lmm_seq_i.exec(1'b1);
        step(1);
        chkm(3'b000);
        rdchk(lmm_pkg::OFS_STATUS, 32'h00000738);
        chk({31'h0, irq}, 32'h00000001);
        rdchk(lmm_pkg::OFS_IRQ_STAT, 32'h00000004);
        wrreg(lmm_pkg::OFS_IRQ_CLR, 32'h00000004);
        step(2);
        chk({31'h0, irq}, 32'h00000000);
        lmm_seq_i.exec(1'b0);
        lmm_seq_i.sel(1'b0, 1'b0);
    endtask
    task automatic t_flags();
        @(posedge clk_in);
        alm_set <= 8'hA5;
        dal_set <= 8'h3C;
        wrn_set <= 8'h81;
        @(posedge clk_in);
        alm_set <= 8'h00;
        dal_set <= 8'h00;
        wrn_set <= 8'h00;
        lmm_seq_i.pulse(1'b0, 1'b1);
        step(1);
        chk({24'h0, wrn}, 32'h00000000);
        chk({16'h0, dal, alm}, 32'h00003CA5);
        rdchk(lmm_pkg::OFS_ALARM, 32'h003C00A5);
        @(posedge clk_in);
        wrn_set <= 8'h42;
        @(posedge clk_in);
        wrn_set <= 8'h00;
        lmm_seq_i.pulse(1'b1, 1'b0);
        step(1);
        chk({16'h0, dal, alm}, 32'h00000000);
        chk({24'h0, wrn}, 32'h00000000);
        rdchk(lmm_pkg::OFS_IRQ_STAT, 32'h00000018);
    endtask

    // ==================================================================
    // Main sequence and watchdog
    initial begin
        sys_rst_in = 1'b1;
        auto_op = 1'b1;
        alm_set = '0;
        dal_set = '0;
        wrn_set = '0;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 4'hF;
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_mode(1'b1, 1'b0, 3'b110);
        t_mode(1'b0, 1'b1, 3'b101);
        t_refuse();
        t_flags();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        $display("FAIL %0t run timeout", $time);
        stop_test();
    end
endmodule
